// File: rtl/bscr_pending_flags.sv
// sticky pending flags: hardware sets, software clears, set wins over clear
`timescale 1ns/1ns
module bscr_pending_flags #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // set and clear strobes, one bit per flag
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // flag state
  output logic      [W-1:0] flags_o
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // an event in the clearing cycle survives the clear
  assign flags_next = set_i | (flags_reg & ~clr_i);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule

// File: rtl/bscr_pkg.sv
// shared constants, field layouts and carrier types of the backup control register bank
package bscr_pkg;

  // register offsets on the peripheral bus (byte addresses)
  localparam logic [9:0] OFS_INT_ENABLE      = 10'h000;
  localparam logic [9:0] OFS_INT_DISABLE     = 10'h004;
  localparam logic [9:0] OFS_INT_MASK        = 10'h008;
  localparam logic [9:0] OFS_PENDING_STATUS  = 10'h00c;
  localparam logic [9:0] OFS_PENDING_CLEAR   = 10'h010;
  localparam logic [9:0] OFS_READY_STATUS    = 10'h014;
  localparam logic [9:0] OFS_UNLOCK          = 10'h018;
  localparam logic [9:0] OFS_XTAL_CONTROL    = 10'h020;

  // implemented bits of the interrupt registers and of the ready-status register
  localparam logic [31:0] PENDING_BITS       = 32'h800017ff;
  localparam logic [31:0] READY_BITS         = 32'h00001fff;
  localparam int          ACCESS_ERROR_BIT   = 31;

  // unlock register fields
  localparam logic [7:0]  UNLOCK_KEY         = 8'haa;
  localparam int          UNLOCK_KEY_LSB     = 24;
  localparam int          UNLOCK_ADDR_W      = 10;

  // crystal oscillator control register
  localparam logic [31:0] XTAL_CTRL_RESET    = 32'h00000004;
  localparam logic [31:0] XTAL_CTRL_WRITABLE = 32'h0007f70d;

  localparam logic [31:0] WORD_ZERO          = 32'h00000000;

  // status levels from the analog and clock sources, bit 12 down to bit 0
  typedef struct packed {
    logic lowpower_bandgap_ready;
    logic one_mhz_rc_ready;
    logic regulator_ok;
    logic buck_stopped_switching;
    logic core_brownout_sync_done;
    logic io_brownout_sync_done;
    logic core_brownout_detected;
    logic io_brownout_detected;
    logic slow_rc_trim_saturated;
    logic slow_rc_reference_lost;
    logic slow_rc_locked;
    logic slow_rc_trim_ready;
    logic slow_crystal_ready;
  } bscr_source_status_t;

  // crystal oscillator control fields as laid out in the register
  typedef struct packed {
    logic       reserved_top;
    logic [11:0] unused_30_19;
    logic [2:0] startup;
    logic [3:0] crystal_drive_current;
    logic       unused_11;
    logic [2:0] mode;
    logic [3:0] unused_7_4;
    logic       one_khz_output_enable;
    logic       thirtytwo_khz_output_enable;
    logic       unused_1;
    logic       slow_crystal_enable;
  } bscr_xtal_ctrl_t;

  // place the source levels at their register bit positions
  function automatic logic [31:0] status_word(input bscr_source_status_t s);
    status_word = {19'h00000, s};
  endfunction

endpackage

// File: rtl/bscr_regs.sv
// backup domain control: interrupt, ready-status, unlock and crystal control registers
`timescale 1ns/1ns

// Function
// - A pending bit sets on its event and holds until cleared.
// - Pending-status reads 1 when pending, 0 when cleared; read-only.
// - Writing one to the clear register clears that pending bit.
// - Writing zero to the clear register changes nothing.
// - Bit 12 reads 1 only when the low-power bandgap is ready.
// - Bit 11 reads 1 only when the 1 MHz RC oscillator is ready.
// - Bit 9 reads 1 once the buck regulator stopped switching on request.
// - Bits 8 and 7 read 0 while brown-out settings synchronise.
// - Bits 6 and 5 set when a brown-out detector sees low supply.
// - Bit 4 sets when slow RC calibration saturates the fine trim.
// - Bit 3 reads 1 when the slow RC reference has stopped.
// - Bit 2 reads 1 once the slow RC oscillator is locked.
// - Bit 1 reads 1 once trim values are valid and writes committed.
// - Bit 0 reads 1 only when the slow crystal oscillator is ready.
// - The unlock arms only with key 0xaa in bits 31 to 24.
// - The unlock takes the 10-bit target offset from bits 9 to 0.
// - Crystal control resets to 0x00000004 only on power-on reset.
// - Enable register sets mask bits; disable register clears them.
// - Crystal control bit 0 switches the slow crystal oscillator on or off.
module bscr_regs (
  // clock and resets
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  input  wire logic                          npor_i,
  // peripheral bus register port, one-cycle access strobe
  input  wire logic                          pb_sel_i,
  input  wire logic                          pb_write_i,
  input  wire logic [9:0]                    pb_addr_i,
  input  wire logic [31:0]                   pb_wdata_i,
  output logic      [31:0]                   pb_rdata_o,
  output logic                               pb_ready_o,
  // status levels from the sources
  input  wire bscr_pkg::bscr_source_status_t source_status_i,
  // controls and interrupt request
  output bscr_pkg::bscr_xtal_ctrl_t          xtal_ctrl_o,
  output logic                               slow_crystal_enable_o,
  output logic                               irq_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire access   = pb_sel_i;
  wire wr       = pb_sel_i & pb_write_i;
  wire rd       = pb_sel_i & ~pb_write_i;
  wire hit_ier  = (pb_addr_i == bscr_pkg::OFS_INT_ENABLE);
  wire hit_idr  = (pb_addr_i == bscr_pkg::OFS_INT_DISABLE);
  wire hit_imr  = (pb_addr_i == bscr_pkg::OFS_INT_MASK);
  wire hit_isr  = (pb_addr_i == bscr_pkg::OFS_PENDING_STATUS);
  wire hit_icr  = (pb_addr_i == bscr_pkg::OFS_PENDING_CLEAR);
  wire hit_pcsr = (pb_addr_i == bscr_pkg::OFS_READY_STATUS);
  wire hit_unl  = (pb_addr_i == bscr_pkg::OFS_UNLOCK);
  wire hit_xtal = (pb_addr_i == bscr_pkg::OFS_XTAL_CONTROL);

  // write strobes; read-only offsets simply ignore writes
  wire wr_ier   = wr & hit_ier;
  wire wr_idr   = wr & hit_idr;
  wire wr_icr   = wr & hit_icr;
  wire wr_unl   = wr & hit_unl;
  wire wr_xtal  = wr & hit_xtal;

  // ---------------------------------------------------------------
  // write protection of the crystal control register
  // ---------------------------------------------------------------
  logic unlock_granted;

  bscr_unlock_guard #(
    .AW (bscr_pkg::UNLOCK_ADDR_W)
  ) u_unlock (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .access_i    (access),
    .unlock_wr_i (wr_unl),
    .key_i       (pb_wdata_i[bscr_pkg::UNLOCK_KEY_LSB +: 8]),
    .key_addr_i  (pb_wdata_i[bscr_pkg::UNLOCK_ADDR_W-1:0]),
    .addr_i      (pb_addr_i),
    .granted_o   (unlock_granted)
  );

  // a locked write is dropped and flagged instead
  wire xtal_write_ok  = wr_xtal & unlock_granted;
  wire xtal_write_bad = wr_xtal & ~unlock_granted;

  // ---------------------------------------------------------------
  // source status sampling
  // ---------------------------------------------------------------
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] status_prev_reg;

  // one flop aligns the levels to the bus clock and keeps reads glitch free
  assign status_next = bscr_pkg::status_word(source_status_i) & bscr_pkg::READY_BITS;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg      <= bscr_pkg::WORD_ZERO;
      status_prev_reg <= bscr_pkg::WORD_ZERO;
    end else begin
      status_reg      <= status_next;
      status_prev_reg <= status_reg;
    end
  end

  // ---------------------------------------------------------------
  // pending events
  // ---------------------------------------------------------------
  logic [31:0] event_set;
  logic [31:0] pending_clr;
  logic [31:0] pending;
  logic [31:0] access_error_set;

  // a rising status level is the event; bit 11 has no pending flag
  assign access_error_set = {xtal_write_bad, 31'h00000000};
  assign event_set   = ((status_reg & ~status_prev_reg) | access_error_set)
                       & bscr_pkg::PENDING_BITS;
  assign pending_clr = (wr_icr ? pb_wdata_i : bscr_pkg::WORD_ZERO)
                       & bscr_pkg::PENDING_BITS;

  bscr_pending_flags #(
    .W (32)
  ) u_pending (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (event_set),
    .clr_i   (pending_clr),
    .flags_o (pending)
  );

  // ---------------------------------------------------------------
  // interrupt mask
  // ---------------------------------------------------------------
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] mask_set;
  logic [31:0] mask_clr;

  // only one access per cycle, so enable and disable never collide
  assign mask_set  = (wr_ier ? pb_wdata_i : bscr_pkg::WORD_ZERO) & bscr_pkg::PENDING_BITS;
  assign mask_clr  = (wr_idr ? pb_wdata_i : bscr_pkg::WORD_ZERO) & bscr_pkg::PENDING_BITS;
  assign mask_next = (mask_reg | mask_set) & ~mask_clr;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_reg <= bscr_pkg::WORD_ZERO;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  logic irq_reg;
  logic irq_next;

  // registered so the output never glitches between pending and mask updates
  assign irq_next = |(pending & mask_reg);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // crystal oscillator control, power-on reset only
  // ---------------------------------------------------------------
  logic [31:0] xtal_reg;
  logic [31:0] xtal_next;

  // reserved and unused bits are never stored, so bit 31 always reads zero
  assign xtal_next = xtal_write_ok ? (pb_wdata_i & bscr_pkg::XTAL_CTRL_WRITABLE)
                                   : xtal_reg;

  // system resets leave this register alone so the crystal keeps running
  always_ff @(posedge clk_i or negedge npor_i) begin
    if (!npor_i) begin
      xtal_reg <= bscr_pkg::XTAL_CTRL_RESET;
    end else begin
      xtal_reg <= xtal_next;
    end
  end

  assign xtal_ctrl_o           = bscr_pkg::bscr_xtal_ctrl_t'(xtal_reg);
  assign slow_crystal_enable_o = xtal_ctrl_o.slow_crystal_enable;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_mux;
  logic        ready_reg;

  // write-only and unmapped offsets read as zero
  always_comb begin
    rd_mux = bscr_pkg::WORD_ZERO;
    if (hit_imr) begin
      rd_mux = mask_reg;
    end else if (hit_isr) begin
      rd_mux = pending;
    end else if (hit_pcsr) begin
      rd_mux = status_reg;
    end else if (hit_xtal) begin
      rd_mux = xtal_reg;
    end
  end

  // read data stands until the next read
  assign rdata_next = rd ? rd_mux : rdata_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= bscr_pkg::WORD_ZERO;
      ready_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ready_reg <= access;
    end
  end

  assign pb_rdata_o = rdata_reg;
  assign pb_ready_o = ready_reg;

endmodule

// File: rtl/bscr_unlock_guard.sv
// one-shot write unlock for a protected register offset
`timescale 1ns/1ns
module bscr_unlock_guard #(
  parameter int AW = 10
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // bus access seen this cycle
  input  wire logic          access_i,
  input  wire logic          unlock_wr_i,
  input  wire logic [7:0]    key_i,
  input  wire logic [AW-1:0] key_addr_i,
  input  wire logic [AW-1:0] addr_i,
  // the current access may write a protected register
  output logic               granted_o
);

  logic          armed_reg;
  logic          armed_next;
  logic [AW-1:0] target_reg;
  logic [AW-1:0] target_next;
  wire           key_ok = (key_i == bscr_pkg::UNLOCK_KEY);

  // the arm lasts for exactly the next access, whatever it is
  assign armed_next  = access_i ? (unlock_wr_i & key_ok) : armed_reg;
  assign target_next = (access_i && unlock_wr_i) ? key_addr_i : target_reg;
  assign granted_o   = armed_reg & (addr_i == target_reg);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_reg  <= 1'b0;
      target_reg <= '0;
    end else begin
      armed_reg  <= armed_next;
      target_reg <= target_next;
    end
  end

endmodule

// File: test/bscr_bus_host.sv
// processor model driving the register port with one-cycle strobes
`timescale 1ns/1ns
module bscr_bus_host (
  // clock
  input  wire logic        clk_i,
  // register port
  output logic             pb_sel_o,
  output logic             pb_write_o,
  output logic [9:0]       pb_addr_o,
  output logic [31:0]      pb_wdata_o,
  input  wire logic [31:0] pb_rdata_i
);
  initial begin
    pb_sel_o = 1'b0;
    pb_write_o = 1'b0;
    pb_addr_o = 10'h3ff;
    pb_wdata_o = 32'h0;
  end
  // one access; read data lands with the ready pulse in the cycle after the strobe
  // status bit 9 is only meaningful while the switching regulator is in use
  task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk_i);
    #1;
    pb_sel_o = 1'b1;
    pb_write_o = wr;
    pb_addr_o = a;
    pb_wdata_o = (a == 10'h020) ? {1'b0, d[30:0]} : d;
    @(posedge clk_i);
    #1;
    pb_sel_o = 1'b0;
    pb_addr_o = ~pb_addr_o; // released address and data lines never keep the old value
    pb_wdata_o = ~pb_wdata_o;
    q = pb_rdata_i;
  endtask
endmodule

// File: test/bscr_regs_assertions.sv
// port checks for the backup control register bank
`timescale 1ns/1ns
module bscr_regs_checker (
  // clock and resets
  input wire logic                          clk_i,
  input wire logic                          nrst_i,
  input wire logic                          npor_i,
  // register port
  input wire logic                          pb_sel_i,
  input wire logic                          pb_write_i,
  input wire logic [9:0]                    pb_addr_i,
  input wire logic [31:0]                   pb_wdata_i,
  input wire logic [31:0]                   pb_rdata_o,
  input wire logic                          pb_ready_o,
  // sources and controls
  input wire bscr_pkg::bscr_source_status_t source_status_i,
  input wire bscr_pkg::bscr_xtal_ctrl_t     xtal_ctrl_o,
  input wire logic                          slow_crystal_enable_o,
  input wire logic                          irq_o
);
  logic armed_reg;
  wire  xtal_wr = pb_sel_i & pb_write_i & (pb_addr_i == 10'h020);
  wire  armed_next = pb_write_i & (pb_addr_i == 10'h018) & (pb_wdata_i[31:24] == 8'haa)
                   & (pb_wdata_i[9:0] == 10'h020);
  // any access consumes the unlock, idle cycles between the two writes do not
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) armed_reg <= 1'b0;
    else if (pb_sel_i) armed_reg <= armed_next;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ready_pulse_a: assert property (pb_ready_o == $past(pb_sel_i))
    else $error("ready pulse does not follow the access");
  status_read_a: assert property (
    pb_sel_i && !pb_write_i && pb_addr_i == 10'h014 |=>
    pb_rdata_o == {19'h00000, $past(source_status_i, 2)})
    else $error("ready status read differs from source levels");
  wo_read_a: assert property (
    pb_sel_i && !pb_write_i && (pb_addr_i == 10'h010 || pb_addr_i == 10'h018) |=>
    pb_rdata_o == 32'h0)
    else $error("write-only register read not zero");
  xtal_en_a: assert property (disable iff (!npor_i)
    slow_crystal_enable_o == xtal_ctrl_o.slow_crystal_enable)
    else $error("oscillator enable differs from control bit 0");
  xtal_rsvd_a: assert property ((xtal_ctrl_o & ~32'h0007f70d) == 32'h0)
    else $error("crystal control shows an unwritable bit");
  xtal_nrst_a: assert property (disable iff (!npor_i) !nrst_i |=> $stable(xtal_ctrl_o))
    else $error("system reset changed crystal control");
  lock_drop_a: assert property (disable iff (!npor_i || !nrst_i)
    xtal_wr && !armed_reg |=> $stable(xtal_ctrl_o))
    else $error("locked crystal control was written");
  lock_grant_a: assert property (disable iff (!npor_i || !nrst_i)
    xtal_wr && armed_reg |=> xtal_ctrl_o == ($past(pb_wdata_i) & 32'h0007f70d))
    else $error("unlocked write did not land");
  cover property (xtal_wr && armed_reg);
  cover property (xtal_wr && !armed_reg);
  cover property ($rose(irq_o));
endmodule
bind bscr_regs bscr_regs_checker chk (.clk_i(clk_i), .nrst_i(nrst_i), .npor_i(npor_i),
  .pb_sel_i(pb_sel_i), .pb_write_i(pb_write_i), .pb_addr_i(pb_addr_i),
  .pb_wdata_i(pb_wdata_i), .pb_rdata_o(pb_rdata_o), .pb_ready_o(pb_ready_o),
  .source_status_i(source_status_i), .xtal_ctrl_o(xtal_ctrl_o),
  .slow_crystal_enable_o(slow_crystal_enable_o), .irq_o(irq_o));

// File: test/bscr_regs_bench.sv
// self-checking bench for the backup control register bank
`timescale 1ns/1ns
module bscr_regs_bench;
  logic                          clk_i, nrst_i, npor_i, sel, wr, rdy, irq, xen;
  logic [9:0]                    addr;
  logic [31:0]                   wd, rd, q;
  bscr_pkg::bscr_source_status_t src;
  bscr_pkg::bscr_xtal_ctrl_t     xc;
  int                            mismatches, samples_checked;
  bscr_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .npor_i(npor_i), .pb_sel_i(sel),
    .pb_write_i(wr), .pb_addr_i(addr), .pb_wdata_i(wd), .pb_rdata_o(rd), .pb_ready_o(rdy),
    .source_status_i(src), .xtal_ctrl_o(xc), .slow_crystal_enable_o(xen), .irq_o(irq));
  bscr_bus_host host (.clk_i(clk_i), .pb_sel_o(sel), .pb_write_o(wr), .pb_addr_o(addr),
    .pb_wdata_o(wd), .pb_rdata_i(rd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [9:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic r(input logic [9:0] a, input logic [31:0] e, input string n);
    host.access(1'b0, a, 32'h0, q);
    chk("ready", {31'h0, rdy}, 32'h1);
    chk(n, q, e);
  endtask
  task automatic t_reset;
    r(10'h00c, 32'h0, "pending");
    r(10'h008, 32'h0, "mask");
    r(10'h020, 32'h4, "xtal");
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask
  // walk one source at a time; every rising level except bit 11 leaves its pending flag behind
  task automatic t_status;
    for (int i = 0; i < 13; i++) begin
      src = 13'h1 << i;
      repeat (3) @(posedge clk_i);
      r(10'h014, 32'h1 << i, "status");
    end
    src = '0;
    r(10'h00c, bscr_pkg::PENDING_BITS & 32'h00001fff, "pending set");
    w(10'h010, 32'h0);
    r(10'h00c, 32'h000017ff, "clear zero");
    w(10'h010, 32'h00000005);
    r(10'h00c, 32'h000017fa, "clear one");
    w(10'h010, 32'hffffffff);
    w(10'h00c, 32'hffffffff);
    r(10'h00c, 32'h0, "pending ro");
    $display("test status done");
  endtask
  task automatic t_irq;
    w(10'h000, 32'h4);
    r(10'h008, 32'h4, "mask set");
    src = 13'h0004;
    repeat (4) @(posedge clk_i);
    #1;
    chk("irq on", {31'h0, irq}, 32'h1);
    w(10'h004, 32'h4);
    @(posedge clk_i);
    #1;
    chk("irq off", {31'h0, irq}, 32'h0);
    src = '0;
    w(10'h010, 32'h4);
    r(10'h00c, 32'h0, "irq cleared");
    $display("test irq done");
  endtask
  task automatic t_lock;
    w(10'h018, 32'h55000020);
    w(10'h020, 32'h1);
    r(10'h020, 32'h4, "bad key");
    r(10'h00c, 32'h80000000, "access error");
    w(10'h018, 32'haa000024);
    w(10'h020, 32'h1);
    r(10'h020, 32'h4, "bad offset");
    w(10'h018, 32'haa000020);
    r(10'h018, 32'h0, "unlock wo");
    w(10'h020, 32'h1);
    r(10'h020, 32'h4, "consumed");
    w(10'h018, 32'haa000020);
    w(10'h020, 32'hffffffff);
    r(10'h020, 32'h0007f70d, "granted");
    chk("xtal out", xc, 32'h0007f70d);
    chk("osc on", {31'h0, xen}, 32'h1);
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    r(10'h020, 32'h0007f70d, "kept");
    r(10'h00c, 32'h0, "pending reset");
    npor_i = 1'b0;
    @(posedge clk_i);
    #1;
    npor_i = 1'b1;
    r(10'h020, 32'h4, "por");
    chk("osc off", {31'h0, xen}, 32'h0);
    $display("test lock done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // the tests need well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    test_done;
  end
  initial begin
    nrst_i = 1'b0;
    npor_i = 1'b0;
    src = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    npor_i = 1'b1;
    t_reset;
    t_status;
    t_irq;
    t_lock;
    test_done;
  end
endmodule
